// ---- hw/glf_ctrl.sv ----
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "glf_params.svh"

module glf_ctrl #(
	parameter int CLK_HZ = `GLF_CLK_HZ
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Register port
	input wire logic [5:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Contact inputs, high when closed
	input wire logic i_run_stop,
	input wire logic i_idle_rated,
	input wire logic i_base_load,
	input wire logic i_unload_request_contact,
	input wire logic i_raise_load,
	input wire logic i_lower_load,
	input wire logic i_remote_sel,
	input wire logic i_droop_sel,
	input wire logic i_speed_fail,
	// Sensor inputs from converters
	input wire logic [15:0] i_load_ua,
	input wire logic [15:0] i_remote_ua,
	input wire logic [15:0] i_boost_ua,
	input wire logic [15:0] i_speed_rpm,
	input wire logic signed [15:0] i_ls_err_mv,
	// Speed controller demand, 0.01 %
	input wire logic [15:0] i_speed_demand,
	// Outputs
	output logic [15:0] o_act_pct,
	output logic [17:0] o_act_ua,
	output logic [15:0] o_speed_ref,
	output logic signed [15:0] o_load_ref,
	output logic signed [15:0] o_gen_load,
	output logic o_breaker_open,
	output logic [1:0] o_speed_mode,
	output logic [2:0] o_load_mode,
	output logic o_cfg_err
);

	// Cycles per millisecond, derived from the clock rate
	localparam int CYC_PER_MS = CLK_HZ / `GLF_MS_PER_S;

	// Whole state of the block
	typedef struct packed {
		logic [`GLF_NCFG-1:0][15:0] cfg; // Set points
		logic [15:0] key; // Configuration key
		logic err; // Rejected write, sticky
		logic [8:0] c1; // Contact sync stage 1
		logic [8:0] c2; // Contact sync stage 2
		logic [4:0][15:0] a1; // Analog sync stage 1
		logic [4:0][15:0] a2; // Analog sync stage 2
		logic run_d; // Previous run/stop level
		logic signed [15:0] load_ref;
		logic [31:0] acc; // Slew accumulator
		logic [2:0] lmode;
		logic [1:0] smode;
		logic brk; // Breaker-open relay
		logic signed [15:0] gen_load;
		logic [15:0] speed_ref;
		logic [15:0] act_pct;
		logic [15:0] rdata;
	} glf_state_s;

	glf_state_s st_ff;
	glf_state_s nxt_st;

	// Linear 4..20 mA scaling to kW
	function automatic logic signed [15:0] map_ma(input logic [15:0] ua,
		input logic signed [15:0] k4, input logic signed [15:0] k20);
		logic signed [47:0] t;
		t = (48'(signed'({1'b0, ua})) - 48'(signed'({1'b0, `GLF_MA4_UA})))
			* (48'(k20) - 48'(k4));
		t = t / `GLF_SPAN_UA;
		map_ma = 16'(48'(k4) + t);
	endfunction

	// One Bresenham step of a slewed reference toward a target
	function automatic glf_pkg::glf_step_s slew(input logic signed [15:0] r,
		input logic signed [15:0] tgt, input logic [31:0] acc,
		input logic [31:0] inc, input logic [31:0] thr);
		glf_pkg::glf_step_s s;
		logic [31:0] a;
		logic [31:0] th;
		s.acc = 32'h0;
		s.ref_kw = r;
		th = (thr == 32'h0) ? 32'h1 : thr;
		a = acc + inc;
		if (r != tgt) begin
			if (a >= th) begin
				// At most one kW per cycle, so no step ever jumps
				s.acc = a - th;
				s.ref_kw = (tgt > r) ? 16'(r + 16'sh1) : 16'(r - 16'sh1);
			end else begin
				s.acc = a;
			end
		end
		slew = s;
	endfunction

	// Decoded inputs after synchronisation
	logic run_c, idle_rated_c, base_c, unl_c, raise_c, lower_c, rem_c, droop_c, fail_c;
	logic [15:0] load_ua, rem_ua, boost_ua, spd_rpm;
	logic signed [15:0] ls_mv;
	assign {fail_c, droop_c, rem_c, lower_c, raise_c, unl_c, base_c, idle_rated_c, run_c} = st_ff.c2;
	assign load_ua = st_ff.a2[0];
	assign rem_ua = st_ff.a2[1];
	assign boost_ua = st_ff.a2[2];
	assign spd_rpm = st_ff.a2[3];
	assign ls_mv = signed'(st_ff.a2[4]);

	// Combinational working values
	logic signed [15:0] kw4_eff;
	logic signed [15:0] gen_load_c;
	logic signed [15:0] rem_tgt;
	logic signed [15:0] max_load;
	logic signed [15:0] base_ref;
	logic signed [15:0] trip;
	logic [15:0] boost_lim;
	logic [15:0] sel_lim;
	logic [15:0] act_c;
	logic signed [47:0] spd_c;
	logic signed [47:0] span;
	logic cfg_ok;
	glf_pkg::glf_step_s stp;

	// Boost-pressure piecewise-linear limit
	always_comb begin
		logic [15:0] xa;
		logic [15:0] xb;
		logic signed [31:0] ya;
		logic signed [31:0] yb;
		logic signed [31:0] q;
		xa = 16'h0;
		xb = 16'h0;
		ya = 32'sh0;
		yb = 32'sh0;
		q = 32'sh0;
		boost_lim = st_ff.cfg[`GLF_C_BPY + 6'(`GLF_NBP - 1)];
		if (boost_ua <= st_ff.cfg[`GLF_C_BPX]) begin
			boost_lim = st_ff.cfg[`GLF_C_BPY];
		end else if (boost_ua >= st_ff.cfg[`GLF_C_BPX + 6'(`GLF_NBP - 1)]) begin
			boost_lim = st_ff.cfg[`GLF_C_BPY + 6'(`GLF_NBP - 1)];
		end else begin
			// Breakpoints ascend, so the last segment that starts below wins
			for (int i = 0; i < `GLF_NBP - 1; i++) begin
				if (boost_ua > st_ff.cfg[`GLF_C_BPX + 6'(i)]) begin
					xa = st_ff.cfg[`GLF_C_BPX + 6'(i)];
					xb = st_ff.cfg[`GLF_C_BPX + 6'(i + 1)];
					ya = 32'(st_ff.cfg[`GLF_C_BPY + 6'(i)]);
					yb = 32'(st_ff.cfg[`GLF_C_BPY + 6'(i + 1)]);
				end
			end
			// Ordering guard for a mis-set table: avoid dividing by zero
			if (xb > xa) begin
				// Signed throughout so a falling limit segment interpolates correctly
				q = ((signed'(32'(boost_ua)) - signed'(32'(xa))) * (yb - ya))
					/ (signed'(32'(xb)) - signed'(32'(xa)));
			end
			boost_lim = 16'(ya + q);
		end
	end

	// Scaling, limits, speed reference
	always_comb begin
		max_load = signed'(st_ff.cfg[`GLF_C_MAX_LOAD]);
		base_ref = signed'(st_ff.cfg[`GLF_C_BASE]);
		trip = signed'(st_ff.cfg[`GLF_C_TRIP]);
		// Centre-zero: lowest current is full reverse, zero at midpoint
		kw4_eff = st_ff.cfg[`GLF_C_CTRL][`GLF_CTRL_CZERO]
			? 16'(-signed'(st_ff.cfg[`GLF_C_KW20]))
			: signed'(st_ff.cfg[`GLF_C_KW4]);
		gen_load_c = map_ma(load_ua, kw4_eff, signed'(st_ff.cfg[`GLF_C_KW20]));
		rem_tgt = map_ma(rem_ua, signed'(st_ff.cfg[`GLF_C_RKW4]),
			signed'(st_ff.cfg[`GLF_C_RKW20]));
		if (rem_tgt > max_load) begin
			rem_tgt = max_load;
		end
		// The contact alone picks the limit, in local and remote alike
		sel_lim = idle_rated_c ? st_ff.cfg[`GLF_C_MAX_FL]
			: st_ff.cfg[`GLF_C_IDLE_FL];
		act_c = (i_speed_demand < sel_lim) ? i_speed_demand : sel_lim;
		if (st_ff.cfg[`GLF_C_CTRL][`GLF_CTRL_BOOST_EN] && boost_lim < act_c) begin
			act_c = boost_lim;
		end
		if (act_c > `GLF_PCT_FULL) begin
			act_c = `GLF_PCT_FULL;
		end
		// Speed reference with droop or load-share bias
		spd_c = 48'(st_ff.cfg[`GLF_C_RATED]);
		if (st_ff.lmode == glf_pkg::GLF_LM_DROOP && st_ff.cfg[`GLF_C_MAX_LOAD] != 16'h0) begin
			// Set points made signed so reverse power and negative error keep their sign
			spd_c = spd_c - (spd_c * signed'(48'(st_ff.cfg[`GLF_C_DROOP]))
				* 48'(st_ff.gen_load)) / (48'(max_load) * `GLF_PCT_SCALE);
		end else if (st_ff.lmode == glf_pkg::GLF_LM_LOADSHARE) begin
			spd_c = spd_c + (spd_c * signed'(48'(st_ff.cfg[`GLF_C_LS_GAIN])) * 48'(ls_mv))
				/ (48'(`GLF_PCT_SCALE) * `GLF_MV_PER_V);
		end
		if (spd_c < 48'sh0) begin
			spd_c = 48'sh0;
		end
		span = 48'(base_ref) - 48'(trip);
		if (span < 48'sh0) begin
			span = -span;
		end
		cfg_ok = (spd_rpm == 16'h0) && !run_c && (st_ff.key == `GLF_KEY_UNLOCK);
	end

	// Next-state logic
	always_comb begin
		logic signed [15:0] tgt;
		logic [31:0] inc;
		logic [31:0] thr;
		tgt = st_ff.load_ref;
		inc = 32'h0;
		thr = 32'(CLK_HZ);
		nxt_st = st_ff;
		stp = '0;
		// Two-flop synchronisers
		nxt_st.c1 = {i_speed_fail, i_droop_sel, i_remote_sel, i_lower_load, i_raise_load,
			i_unload_request_contact, i_base_load, i_idle_rated, i_run_stop};
		nxt_st.c2 = st_ff.c1;
		nxt_st.a1 = {i_ls_err_mv, i_speed_rpm, i_boost_ua, i_remote_ua, i_load_ua};
		nxt_st.a2 = st_ff.a1;
		nxt_st.run_d = run_c;
		nxt_st.gen_load = gen_load_c;
		nxt_st.act_pct = act_c;
		nxt_st.speed_ref = 16'(spd_c);

		// Load control sequencing
		if (!unl_c) begin
			// Unload: ramp down, trip breaker at the trip level
			tgt = trip;
			inc = 32'(span);
			thr = 32'(st_ff.cfg[`GLF_C_UNLOAD_MS]) * 32'(CYC_PER_MS);
			if (gen_load_c <= trip) begin
				nxt_st.brk = 1'b1;
			end
			nxt_st.lmode = (st_ff.brk || gen_load_c <= trip)
				? glf_pkg::GLF_LM_UNLOAD_TRIP : glf_pkg::GLF_LM_UNLOAD_RAMP;
		end else begin
			nxt_st.brk = 1'b0;
			if (base_c) begin
				tgt = base_ref;
				inc = 32'(span);
				thr = 32'(st_ff.cfg[`GLF_C_LOAD_MS]) * 32'(CYC_PER_MS);
				nxt_st.lmode = (st_ff.load_ref == base_ref)
					? glf_pkg::GLF_LM_BASE : glf_pkg::GLF_LM_LOAD_RAMP;
			end else if (rem_c) begin
				tgt = rem_tgt;
				nxt_st.lmode = glf_pkg::GLF_LM_REMOTE;
			end else begin
				if (raise_c && !lower_c) begin
					tgt = max_load;
				end else if (lower_c && !raise_c) begin
					tgt = 16'sh0;
				end
				nxt_st.lmode = droop_c ? glf_pkg::GLF_LM_DROOP
					: glf_pkg::GLF_LM_LOADSHARE;
			end
			// Raise and lower move at their own rates
			if (!base_c) begin
				inc = (tgt > st_ff.load_ref) ? 32'(st_ff.cfg[`GLF_C_RAISE])
					: 32'(st_ff.cfg[`GLF_C_LOWER]);
			end
		end
		if (tgt > max_load) begin
			tgt = max_load;
		end
		stp = slew(st_ff.load_ref, tgt, st_ff.acc, inc, thr);
		nxt_st.acc = stp.acc;
		nxt_st.load_ref = stp.ref_kw;
		if (nxt_st.load_ref > max_load) begin
			nxt_st.load_ref = max_load;
		end

		// Speed control mode
		if (!run_c) begin
			nxt_st.smode = glf_pkg::GLF_SM_STOP;
		end else if (fail_c) begin
			nxt_st.smode = glf_pkg::GLF_SM_FAILSAFE;
		end else if (act_c < i_speed_demand) begin
			nxt_st.smode = glf_pkg::GLF_SM_FUEL_LIM;
		end else begin
			nxt_st.smode = glf_pkg::GLF_SM_SPEED;
		end

		// Register writes; key is writable in every cycle without a run/stop edge
		if (i_wr) begin
			if (i_addr == `GLF_R_KEY) begin
				nxt_st.key = i_wdata;
			end else if (i_addr == `GLF_R_STATUS) begin
				if (i_wdata[`GLF_ST_ERR]) begin
					nxt_st.err = 1'b0;
				end
			end else if (i_addr < 6'(`GLF_NCFG)) begin
				if (cfg_ok) begin
					nxt_st.cfg[i_addr] = i_wdata;
				end
			end
		end
		// Rejection wins over a clear in the same cycle
		if (i_wr && i_addr < 6'(`GLF_NCFG) && !cfg_ok) begin
			nxt_st.err = 1'b1;
		end
		// Run/stop edge wipes the key, over any write
		if (run_c != st_ff.run_d) begin
			nxt_st.key = `GLF_KEY_CLEAR;
		end

		// Read data, valid the cycle after the strobe only
		nxt_st.rdata = 16'h0;
		if (i_rd) begin
			if (i_addr < 6'(`GLF_NCFG)) begin
				nxt_st.rdata = st_ff.cfg[i_addr];
			end else begin
				case (i_addr)
					`GLF_R_KEY: nxt_st.rdata = st_ff.key;
					`GLF_R_STATUS: nxt_st.rdata = {9'h0, st_ff.lmode, st_ff.smode,
						st_ff.brk, st_ff.err};
					`GLF_R_GEN_LOAD: nxt_st.rdata = st_ff.gen_load;
					`GLF_R_LOAD_REF: nxt_st.rdata = st_ff.load_ref;
					`GLF_R_SPEED_REF: nxt_st.rdata = st_ff.speed_ref;
					`GLF_R_ACT_PCT: nxt_st.rdata = st_ff.act_pct;
					default: nxt_st.rdata = 16'h0;
				endcase
			end
		end
	end

	// State register; reset loads constants only
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_ff <= '0;
			st_ff.cfg[`GLF_C_LS_GAIN] <= `GLF_RST_LS_GAIN;
			st_ff.cfg[`GLF_C_MAX_FL] <= `GLF_RST_MAX_FL;
			st_ff.cfg[`GLF_C_IDLE_FL] <= `GLF_RST_IDLE_FL;
			st_ff.cfg[`GLF_C_LOAD_MS] <= `GLF_RST_RAMP_MS;
			st_ff.cfg[`GLF_C_UNLOAD_MS] <= `GLF_RST_RAMP_MS;
			st_ff.cfg[`GLF_C_RATED] <= `GLF_RST_RATED;
			st_ff.key <= `GLF_KEY_CLEAR;
			st_ff.lmode <= glf_pkg::GLF_LM_DROOP;
			st_ff.smode <= glf_pkg::GLF_SM_STOP;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs, all from flip-flops
	assign o_rdata = st_ff.rdata;
	assign o_act_pct = st_ff.act_pct;
	// Full scale is 200 mA, so 0.01 % is 20 uA
	assign o_act_ua = 18'((32'(st_ff.act_pct) * `GLF_ACT_FULL_UA) / `GLF_PCT_SCALE);
	assign o_speed_ref = st_ff.speed_ref;
	assign o_load_ref = st_ff.load_ref;
	assign o_gen_load = st_ff.gen_load;
	assign o_breaker_open = st_ff.brk;
	assign o_speed_mode = st_ff.smode;
	assign o_load_mode = st_ff.lmode;
	assign o_cfg_err = st_ff.err;

endmodule

// ---- hw/glf_params.svh ----
`ifndef GLF_PARAMS_SVH
`define GLF_PARAMS_SVH

// Timing
`define GLF_CLK_HZ 40000000
`define GLF_MS_PER_S 1000

// Analog scaling, currents in microamps, percents in 0.01 %
`define GLF_MA4_UA 16'h0FA0
`define GLF_MA20_UA 16'h4E20
`define GLF_SPAN_UA 16000
`define GLF_PCT_FULL 16'h2710
`define GLF_ACT_FULL_UA 200000
`define GLF_PCT_SCALE 10000
`define GLF_MV_PER_V 1000

// Configuration key
`define GLF_KEY_UNLOCK 16'h0031
`define GLF_KEY_CLEAR 16'h0000

// Configuration word indices
`define GLF_C_MAX_LOAD 6'h00
`define GLF_C_LS_GAIN 6'h01
`define GLF_C_KW4 6'h02
`define GLF_C_KW20 6'h03
`define GLF_C_BASE 6'h04
`define GLF_C_TRIP 6'h05
`define GLF_C_LOAD_MS 6'h06
`define GLF_C_UNLOAD_MS 6'h07
`define GLF_C_RAISE 6'h08
`define GLF_C_LOWER 6'h09
`define GLF_C_RKW4 6'h0A
`define GLF_C_RKW20 6'h0B
`define GLF_C_DROOP 6'h0C
`define GLF_C_IDLE_FL 6'h0D
`define GLF_C_MAX_FL 6'h0E
`define GLF_C_CTRL 6'h0F
`define GLF_C_BPX 6'h10
`define GLF_C_BPY 6'h15
`define GLF_C_RATED 6'h1A
`define GLF_NCFG 27

// Other registers
`define GLF_R_KEY 6'h1F
`define GLF_R_STATUS 6'h20
`define GLF_R_GEN_LOAD 6'h21
`define GLF_R_LOAD_REF 6'h22
`define GLF_R_SPEED_REF 6'h23
`define GLF_R_ACT_PCT 6'h24

// Control word bits
`define GLF_CTRL_BOOST_EN 0
`define GLF_CTRL_CZERO 1
// Status word bits
`define GLF_ST_ERR 0
`define GLF_ST_BRK 1
`define GLF_ST_SMODE 2
`define GLF_ST_LMODE 4

// Reset values and breakpoint count
`define GLF_RST_LS_GAIN 16'h00A7
`define GLF_RST_MAX_FL 16'h2710
`define GLF_RST_IDLE_FL 16'h07D0
`define GLF_RST_RAMP_MS 16'h2710
`define GLF_RST_RATED 16'h0708
`define GLF_NBP 5

`endif

// ---- hw/glf_pkg.sv ----
package glf_pkg;
	// Speed control mode
	typedef enum logic [1:0] {
		GLF_SM_STOP = 2'b00,
		GLF_SM_FAILSAFE = 2'b01,
		GLF_SM_FUEL_LIM = 2'b10,
		GLF_SM_SPEED = 2'b11
	} glf_smode_e;
	// Load control mode
	typedef enum logic [2:0] {
		GLF_LM_BASE = 3'b000,
		GLF_LM_UNLOAD_RAMP = 3'b001,
		GLF_LM_UNLOAD_TRIP = 3'b010,
		GLF_LM_LOAD_RAMP = 3'b011,
		GLF_LM_DROOP = 3'b100,
		GLF_LM_LOADSHARE = 3'b101,
		GLF_LM_REMOTE = 3'b110
	} glf_lmode_e;
	// One slew step result
	typedef struct packed {
		logic [31:0] acc;
		logic signed [15:0] ref_kw;
	} glf_step_s;
endpackage

// ---- testbench/glf_ctrl_properties.sv ----
`timescale 1ns/1ps
// Port-level checks on the load and fuel limit block
module glf_ctrl_props (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Inputs watched
	input wire logic [5:0] i_addr,
	input wire logic i_wr,
	input wire logic i_run_stop,
	input wire logic i_speed_fail,
	input wire logic [15:0] i_speed_demand,
	// Outputs watched
	input wire logic [15:0] o_act_pct,
	input wire logic [17:0] o_act_ua,
	input wire logic signed [15:0] o_load_ref,
	input wire logic o_breaker_open,
	input wire logic [1:0] o_speed_mode,
	input wire logic [2:0] o_load_mode,
	input wire logic o_cfg_err
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// Four samples cover the two-stage synchroniser plus the output register
	sequence s_running;
		i_run_stop [*4];
	endsequence
	sequence s_stopped;
		(!i_run_stop && !i_speed_fail) [*4];
	endsequence
	sequence s_cfg_wr;
		i_wr && (i_addr <= 6'h1A);
	endsequence
	chk_act_ua_scale: assert property (o_act_ua == 18'(o_act_pct) * 18'h14)
		else $error("actuator current not twenty times percent");
	chk_act_full_cap: assert property (o_act_pct <= 16'h2710)
		else $error("actuator percent above full scale");
	// Demand held three edges must bound the output
	chk_act_demand_min: assert property ($stable(i_speed_demand) [*3] |-> o_act_pct <= i_speed_demand)
		else $error("actuator above speed demand");
	chk_ref_no_step: assert property ((o_load_ref - $past(o_load_ref)) inside {16'hFFFF, 16'h0000, 16'h0001})
		else $error("load reference stepped");
	chk_brk_unload: assert property ($rose(o_breaker_open) |-> o_load_mode inside {3'h1, 3'h2})
		else $error("breaker opened outside unload");
	chk_lmode_legal: assert property (o_load_mode != 3'h7)
		else $error("load mode code unused");
	chk_stop_mode: assert property (s_stopped |-> o_speed_mode == glf_pkg::GLF_SM_STOP)
		else $error("stopped engine not in stop mode");
	chk_fail_mode: assert property ((i_run_stop && i_speed_fail) [*4] |-> o_speed_mode == 2'h1)
		else $error("speed failure not in failsafe mode");
	chk_cfg_refused: assert property (s_running ##0 s_cfg_wr |=> o_cfg_err)
		else $error("config write while running not flagged");
endmodule

bind glf_ctrl glf_ctrl_props u_props (
	.i_clk(i_clk),
	.i_resetn(i_resetn),
	.i_addr(i_addr),
	.i_wr(i_wr),
	.i_run_stop(i_run_stop),
	.i_speed_fail(i_speed_fail),
	.i_speed_demand(i_speed_demand),
	.o_act_pct(o_act_pct),
	.o_act_ua(o_act_ua),
	.o_load_ref(o_load_ref),
	.o_breaker_open(o_breaker_open),
	.o_speed_mode(o_speed_mode),
	.o_load_mode(o_load_mode),
	.o_cfg_err(o_cfg_err)
);

// ---- testbench/glf_plant_model.sv ----
`timescale 1ns/1ps
// Generator power transducer, 4 mA at zero load
module glf_plant_model #(
	parameter int UA_PER_KW = 10
) (
	// Clock
	input wire logic i_clk,
	// Load source: bench command or engine tracking the reference
	input wire logic i_follow,
	input wire logic signed [15:0] i_kw_cmd,
	input wire logic signed [15:0] i_load_ref,
	// Transducer current
	output logic [15:0] o_load_ua
);
	logic signed [15:0] kw;
	// Ideal engine: real units lag more, this one lags a cycle
	assign kw = i_follow ? i_load_ref : i_kw_cmd;
	initial o_load_ua = 16'h0FA0;
	always @(posedge i_clk) begin
		o_load_ua <= 16'h0FA0 + 16'(UA_PER_KW * kw);
	end
endmodule

// ---- testbench/tb_glf_ctrl.sv ----
`timescale 1ns/1ps
module tb_glf_ctrl;
	// Short rate base, 1 ms is 40 cycles
	localparam int CLK_HZ = 40000;
	localparam int LIMIT = 20000;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [5:0] i_addr = 6'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	// Contacts, high when closed
	logic run = 1'b0, rated = 1'b0, base = 1'b0, unl = 1'b1, raise = 1'b0;
	logic lower = 1'b0, remote = 1'b0, droop = 1'b1, sfail = 1'b0, follow = 1'b0;
	// Sensors
	logic [15:0] load_ua, rem_ua = 16'h0FA0, boost_ua = 16'h0BB8, rpm = 16'h0000;
	logic [15:0] demand = 16'h251C;
	logic signed [15:0] ls_mv = 16'sh0000, kw_cmd = 16'sh0000;
	// Observed outputs
	logic [15:0] rdata, act_pct, speed_ref;
	logic [17:0] act_ua;
	logic signed [15:0] load_ref, gen_load;
	logic brk, cerr;
	logic [1:0] smode;
	logic [2:0] lmode;
	int err_total = 0;
	int checks = 0;
	int cyc_n = 0;
	// Setup words outside the breakpoint table
	logic [5:0] ca [11] = '{6'h00, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0B,
		6'h0C, 6'h0E};
	logic [15:0] cd [11] = '{16'h03E8, 16'h0640, 16'h00C8, 16'h0028, 16'h000A, 16'h000A,
		16'h4E20, 16'h9C40, 16'h00A0, 16'h01F4, 16'h2328};
	logic [15:0] bu [5] = '{16'h0BB8, 16'h0FA0, 16'h1770, 16'h36B0, 16'h4E20};
	logic [15:0] be [5] = '{16'h05DC, 16'h05DC, 16'h08CA, 16'h1482, 16'h1D4C};

	glf_ctrl #(.CLK_HZ(CLK_HZ)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_run_stop(run),
		.i_idle_rated(rated), .i_base_load(base), .i_unload_request_contact(unl),
		.i_raise_load(raise), .i_lower_load(lower), .i_remote_sel(remote),
		.i_droop_sel(droop), .i_speed_fail(sfail), .i_load_ua(load_ua),
		.i_remote_ua(rem_ua), .i_boost_ua(boost_ua), .i_speed_rpm(rpm),
		.i_ls_err_mv(ls_mv), .i_speed_demand(demand), .o_act_pct(act_pct),
		.o_act_ua(act_ua), .o_speed_ref(speed_ref), .o_load_ref(load_ref),
		.o_gen_load(gen_load), .o_breaker_open(brk), .o_speed_mode(smode),
		.o_load_mode(lmode), .o_cfg_err(cerr));
	glf_plant_model plant (.i_clk(i_clk), .i_follow(follow), .i_kw_cmd(kw_cmd),
		.i_load_ref(load_ref), .o_load_ua(load_ua));

	always #12.5 i_clk = ~i_clk;
	// Hang guard
	always @(posedge i_clk) begin
		cyc_n++;
		if (cyc_n == LIMIT) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// Reads at an edge see the value held through the cycle before it
	task automatic rng(input logic signed [15:0] lo, input logic signed [15:0] hi);
		chk(18'(load_ref >= lo && load_ref <= hi), 18'h1);
	endtask
	// Idle cycle after each strobe keeps every signal to one change a step
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rc(input logic [5:0] a, input logic [15:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
		chk(18'(rdata), 18'(e));
	endtask
	// Stop, unlock, write, restart
	task automatic cfg_w(input logic [5:0] a, input logic [15:0] d);
		run <= 1'b0;
		cyc(4);
		wr(6'h1F, 16'h0031);
		wr(a, d);
		run <= 1'b1;
		cyc(4);
	endtask

	task automatic t_lock();
		rc(6'h01, 16'h00A7);
		rc(6'h0E, 16'h2710);
		rc(6'h3F, 16'h0000);
		wr(6'h00, 16'h03E8);
		chk(cerr, 18'h1);
		rc(6'h00, 16'h0000);
		wr(6'h20, 16'h0001);
		wr(6'h1F, 16'h0031);
		run <= 1'b1;
		cyc(4);
		rc(6'h1F, 16'h0000);
		chk(cerr, 18'h0);
		wr(6'h00, 16'h03E8);
		chk(cerr, 18'h1);
		run <= 1'b0;
		cyc(4);
		wr(6'h1F, 16'h0031);
		rpm <= 16'h0064;
		cyc(4);
		wr(6'h20, 16'h0001);
		wr(6'h00, 16'h03E8);
		chk(cerr, 18'h1);
		rpm <= 16'h0000;
		cyc(4);
		wr(6'h20, 16'h0001);
		for (int i = 0; i < 11; i++) wr(ca[i], cd[i]);
		// Ascending breakpoints, 4 to 20 mA
		for (int i = 0; i < 5; i++) wr(6'h10 + 6'(i), 16'(16'h0FA0 * (i + 1)));
		for (int i = 0; i < 5; i++) wr(6'h15 + 6'(i), 16'(16'h05DC * (i + 1)));
		chk(cerr, 18'h0);
		rc(6'h00, 16'h03E8);
	endtask

	task automatic t_fuel();
		run <= 1'b1;
		cyc(5);
		chk(act_pct, 18'h007D0);
		chk(act_ua, 18'h09C40);
		chk(smode, 18'h2);
		remote <= 1'b1;
		cyc(5);
		chk(act_pct, 18'h007D0);
		rated <= 1'b1;
		cyc(5);
		chk(act_pct, 18'h02328);
		remote <= 1'b0;
		demand <= 16'h1388;
		cyc(5);
		chk(act_pct, 18'h01388);
		chk(smode, 18'h3);
		sfail <= 1'b1;
		cyc(5);
		chk(smode, 18'h1);
		sfail <= 1'b0;
		run <= 1'b0;
		cyc(5);
		chk(smode, 18'h0);
		demand <= 16'h251C;
	endtask

	task automatic t_boost();
		run <= 1'b1;
		cyc(5);
		chk(act_pct, 18'h02328);
		cfg_w(6'h0F, 16'h0001);
		for (int i = 0; i < 5; i++) begin
			boost_ua <= bu[i];
			cyc(5);
			chk(act_pct, be[i]);
		end
	endtask

	task automatic t_speed();
		kw_cmd <= 16'sh01F4;
		cyc(8);
		chk(gen_load, 18'h001F4);
		chk(speed_ref, 18'h006DB);
		chk(lmode, 18'h4);
		droop <= 1'b0;
		ls_mv <= 16'sh03E8;
		cyc(8);
		chk(speed_ref, 18'h00726);
		chk(lmode, 18'h5);
		// Negative bridge error lowers the reference
		ls_mv <= 16'shFC18;
		cyc(8);
		chk(speed_ref, 18'h006EA);
		cfg_w(6'h0F, 16'h0002);
		kw_cmd <= 16'sh0000;
		cyc(6);
		chk(gen_load, 18'h3F9C0);
		kw_cmd <= 16'sh0320;
		cyc(6);
		chk(gen_load, 18'h00000);
		cfg_w(6'h0F, 16'h0000);
	endtask

	task automatic t_slew();
		raise <= 1'b1;
		cyc(200);
		rng(16'sh005F, 16'sh0064);
		cyc(2000);
		chk(load_ref, 18'h003E8);
		raise <= 1'b0;
		lower <= 1'b1;
		cyc(100);
		rng(16'sh0383, 16'sh0389);
		lower <= 1'b0;
		remote <= 1'b1;
		rem_ua <= 16'h2EE0;
		cyc(900);
		chk(load_ref, 18'h00050);
		rem_ua <= 16'h4E20;
		cyc(100);
		rng(16'sh007D, 16'sh0082);
		cyc(100);
		chk(load_ref, 18'h000A0);
		remote <= 1'b0;
	endtask

	task automatic t_ramp();
		follow <= 1'b1;
		base <= 1'b1;
		cyc(10);
		chk(lmode, 18'h3);
		cyc(60);
		rng(16'sh00B7, 16'sh00BD);
		cyc(100);
		chk(load_ref, 18'h000C8);
		chk(lmode, 18'h0);
		unl <= 1'b0;
		cyc(10);
		chk(lmode, 18'h1);
		cyc(190);
		rng(16'sh0076, 16'sh007E);
		chk(brk, 18'h0);
		cyc(250);
		chk(load_ref, 18'h00028);
		chk(brk, 18'h1);
		chk(lmode, 18'h2);
		unl <= 1'b1;
		cyc(6);
		chk(brk, 18'h0);
		// Status word: load ramp, fuel limiter, breaker closed, no error
		rc(6'h20, 16'h0038);
		rc(6'h24, 16'h2328);
	endtask

	initial begin
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_lock();
		t_fuel();
		t_boost();
		t_speed();
		t_slew();
		t_ramp();
		report_and_stop();
	end
endmodule
